/* rtl/vic_map.svh */
// Register map, field positions and constants of the interrupt controller
// Assumes word-aligned AHB-Lite access, byte address = 4 * index
//
// Operation
// - Five sources: external pin, timer 0, timer 1, interval timer, serial
// - Accept only with global accept flag and source enable both set
// - Software can read and clear every request flag for polling
// - Nesting limited to three levels
// - Enabled pending request releases stop or halt standby
// - Acceptance pushes bank register and five core flags, three levels
// - Data buffer and window register are not saved by hardware
// - Acceptance branches to a fixed per-source vector
// - Vectors: external pin 0005H, timer 0 0004H, timer 1 0003H
// - Vectors: interval timer 0002H, serial 0001H
// - Fixed priority: pin, timer 0, timer 1, interval timer, serial
// - A source event sets its request flag to 1
// - Start of service clears that source's request flag
// - Each source has an enable flag, 1 enables, 0 disables
// - External edge selected by edge-select bits at location 1FH
// - Accept op sets global flag; acceptance and mask op clear it
// - Reset clears the global accept flag
// - Edge select: 00 rising, 01 falling, 10 or 11 both
// - Writing 0 to the pin request flag cancels it
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH

// Register indices
`define VIC_IDX_PIN_LEVEL   6'h0f
`define VIC_IDX_EDGE_SEL    6'h1f
`define VIC_IDX_SIO_EN      6'h2e
`define VIC_IDX_SRC_EN      6'h2f
`define VIC_IDX_REQ_SIO     6'h3b
`define VIC_IDX_REQ_BTM     6'h3c
`define VIC_IDX_REQ_TM1     6'h3d
`define VIC_IDX_REQ_TM0     6'h3e
`define VIC_IDX_REQ_EXT     6'h3f
`define VIC_IDX_STATUS      6'h10

// Source positions, index order is priority order
`define VIC_SRC_EXT         0
`define VIC_SRC_TM0         1
`define VIC_SRC_TM1         2
`define VIC_SRC_BTM         3
`define VIC_SRC_SIO         4
`define VIC_NUM_SRC         5

// Vector addresses
`define VIC_VEC_EXT         16'h0005
`define VIC_VEC_TM0         16'h0004
`define VIC_VEC_TM1         16'h0003
`define VIC_VEC_BTM         16'h0002
`define VIC_VEC_SIO         16'h0001

// Edge select codes
`define VIC_EDGE_RISE       2'h0
`define VIC_EDGE_FALL       2'h1

// Nesting and reset values
`define VIC_NEST_DEPTH      2'h3
`define VIC_RST_EDGE        2'h0
`define VIC_RST_EN          5'h00
`define VIC_RST_REQ         5'h00

`endif

/* rtl/vic_pkg.sv */
// Types shared by the interrupt controller modules
// Assumes the constants in vic_map.svh
package vic_pkg;

   typedef enum logic [0:0] {
      VIC_IDLE  = 1'b0,
      VIC_OFFER = 1'b1
   } vic_state_t;

   typedef logic [4:0] vic_src_t;

endpackage

/* rtl/vic_pin_sync.sv */
// Three-stage synchroniser with agreement filter and edge pulses
// Assumes an asynchronous pin and one synchronous reset
`timescale 1ns/1ns
module vic_pin_sync (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic srst_i,
   // Pin and results
   input  wire logic pin_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic       level_reg;
   logic       level_next;
   logic       rise_reg;
   logic       rise_next;
   logic       fall_reg;
   logic       fall_next;

   // First stage feeds only the second; level moves when stages 2 and 3 agree
   always_comb begin
      sync_next  = {sync_reg[1:0], pin_i};
      level_next = level_reg;
      if (sync_reg[1] == sync_reg[2]) begin
         level_next = sync_reg[2];
      end
      rise_next = level_next & ~level_reg;
      fall_next = ~level_next & level_reg;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sync_reg  <= 3'h0;
         level_reg <= 1'b0;
         rise_reg  <= 1'b0;
         fall_reg  <= 1'b0;
      end else begin
         sync_reg  <= sync_next;
         level_reg <= level_next;
         rise_reg  <= rise_next;
         fall_reg  <= fall_next;
      end
   end

   assign level_o = level_reg;
   assign rise_o  = rise_reg;
   assign fall_o  = fall_reg;

endmodule

/* rtl/vic_top.sv */
// Vectored interrupt controller with AHB-Lite register slave
// Assumes a core sequencer that acknowledges offers and signals returns
`timescale 1ns/1ns
`include "vic_map.svh"
module vic_top
   import vic_pkg::*;
#(
   parameter int PC_W = 16
) (
   // Clock and reset
   input  wire logic            REF_CLK_I,
   input  wire logic            SRST_I,
   // AHB-Lite slave
   input  wire logic            HSEL_I,
   input  wire logic [7:0]      HADDR_I,
   input  wire logic [1:0]      HTRANS_I,
   input  wire logic            HWRITE_I,
   input  wire logic [2:0]      HSIZE_I,
   input  wire logic [31:0]     HWDATA_I,
   input  wire logic            HREADY_I,
   output logic      [31:0]     HRDATA_O,
   output logic                 HREADYOUT_O,
   output logic                 HRESP_O,
   // Interrupt sources
   input  wire logic            EXT_PIN_I,
   input  wire logic            TM0_MATCH_I,
   input  wire logic            TM1_MATCH_I,
   input  wire logic            BTM_OVF_I,
   input  wire logic            SIO_END_I,
   // Core instruction events
   input  wire logic            ACCEPT_ON_OP_I,
   input  wire logic            MASK_ALL_OP_I,
   input  wire logic            ENTRY_ACK_I,
   input  wire logic            RETURN_I,
   // Core state to save
   input  wire logic [PC_W-1:0] RET_ADDR_I,
   input  wire logic [3:0]      BANK_I,
   input  wire logic [4:0]      CORE_FLAGS_I,
   // Core requests and restores
   output logic                 IRQ_REQ_O,
   output logic      [PC_W-1:0] VECTOR_O,
   output logic                 VECTOR_FETCH_O,
   output logic                 STANDBY_WAKE_O,
   output logic      [PC_W-1:0] RESTORE_ADDR_O,
   output logic      [3:0]      RESTORE_BANK_O,
   output logic      [4:0]      RESTORE_FLAGS_O,
   output logic                 RESTORE_VALID_O
);

   localparam int FRAME_W = PC_W + 9;

   // ****************************************
   // External pin conditioning
   // ****************************************
   logic pin_level;
   logic pin_rise;
   logic pin_fall;

   vic_pin_sync u_pin_sync (
      .clk_i   (REF_CLK_I),
      .srst_i  (SRST_I),
      .pin_i   (EXT_PIN_I),
      .level_o (pin_level),
      .rise_o  (pin_rise),
      .fall_o  (pin_fall)
   );

   // ****************************************
   // Bus slave
   // ****************************************
   logic        wr_pend_reg;
   logic        wr_pend_next;
   logic [5:0]  wr_idx_reg;
   logic [5:0]  wr_idx_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        ready_reg;
   logic        addr_ok;

   logic [1:0]  edge_reg;
   logic [1:0]  edge_next;
   vic_src_t    en_reg;
   vic_src_t    en_next;
   vic_src_t    req_reg;
   vic_src_t    req_next;
   logic        accept_reg;
   logic        accept_next;
   logic [1:0]  depth_reg;
   logic [1:0]  depth_next;

   function automatic logic [31:0] read_mux(input logic [5:0] idx);
      logic [31:0] d;
      d = 32'h0;
      case (idx)
         `VIC_IDX_PIN_LEVEL: d[0] = pin_level;
         `VIC_IDX_EDGE_SEL:  d[1:0] = edge_reg;
         `VIC_IDX_SIO_EN:    d[0] = en_reg[`VIC_SRC_SIO];
         `VIC_IDX_SRC_EN:    d[3:0] = en_reg[3:0];
         `VIC_IDX_REQ_SIO:   d[0] = req_reg[`VIC_SRC_SIO];
         `VIC_IDX_REQ_BTM:   d[0] = req_reg[`VIC_SRC_BTM];
         `VIC_IDX_REQ_TM1:   d[0] = req_reg[`VIC_SRC_TM1];
         `VIC_IDX_REQ_TM0:   d[0] = req_reg[`VIC_SRC_TM0];
         `VIC_IDX_REQ_EXT:   d[0] = req_reg[`VIC_SRC_EXT];
         `VIC_IDX_STATUS:    d[2:0] = {depth_reg, accept_reg};
         default:            d = 32'h0;
      endcase
      return d;
   endfunction

   // Zero wait states; unmapped reads give zero, writes vanish
   always_comb begin
      addr_ok      = HSEL_I & HREADY_I & HTRANS_I[1];
      wr_pend_next = addr_ok & HWRITE_I;
      wr_idx_next  = HADDR_I[7:2];
      rdata_next   = 32'h0;
      if (addr_ok & ~HWRITE_I) begin
         rdata_next = read_mux(HADDR_I[7:2]);
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= 6'h0;
         rdata_reg   <= 32'h0;
         ready_reg   <= 1'b0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_idx_reg  <= wr_idx_next;
         rdata_reg   <= rdata_next;
         ready_reg   <= 1'b1;
      end
   end

   // ****************************************
   // Request and enable flags
   // ****************************************
   vic_src_t src_evt;
   vic_src_t sw_wr;
   vic_src_t take_src;
   logic     ext_evt;
   logic     take;

   always_comb begin
      case (edge_reg)
         `VIC_EDGE_RISE: ext_evt = pin_rise;
         `VIC_EDGE_FALL: ext_evt = pin_fall;
         default:        ext_evt = pin_rise | pin_fall;
      endcase
   end

   assign src_evt = {SIO_END_I, BTM_OVF_I, TM1_MATCH_I, TM0_MATCH_I, ext_evt};

   always_comb begin
      sw_wr = 5'h0;
      if (wr_pend_reg) begin
         sw_wr[`VIC_SRC_EXT] = (wr_idx_reg == `VIC_IDX_REQ_EXT);
         sw_wr[`VIC_SRC_TM0] = (wr_idx_reg == `VIC_IDX_REQ_TM0);
         sw_wr[`VIC_SRC_TM1] = (wr_idx_reg == `VIC_IDX_REQ_TM1);
         sw_wr[`VIC_SRC_BTM] = (wr_idx_reg == `VIC_IDX_REQ_BTM);
         sw_wr[`VIC_SRC_SIO] = (wr_idx_reg == `VIC_IDX_REQ_SIO);
      end
   end

   // A new event always beats a clear in the same cycle
   always_comb begin
      req_next  = req_reg;
      en_next   = en_reg;
      edge_next = edge_reg;
      for (int i = 0; i < `VIC_NUM_SRC; i++) begin
         if (sw_wr[i]) begin
            req_next[i] = HWDATA_I[0];
         end else if (take & take_src[i]) begin
            req_next[i] = 1'b0;
         end
         if (src_evt[i]) begin
            req_next[i] = 1'b1;
         end
      end
      if (wr_pend_reg & (wr_idx_reg == `VIC_IDX_SRC_EN)) begin
         en_next[3:0] = HWDATA_I[3:0];
      end
      if (wr_pend_reg & (wr_idx_reg == `VIC_IDX_SIO_EN)) begin
         en_next[`VIC_SRC_SIO] = HWDATA_I[0];
      end
      if (wr_pend_reg & (wr_idx_reg == `VIC_IDX_EDGE_SEL)) begin
         edge_next = HWDATA_I[1:0];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         req_reg  <= `VIC_RST_REQ;
         en_reg   <= `VIC_RST_EN;
         edge_reg <= `VIC_RST_EDGE;
      end else begin
         req_reg  <= req_next;
         en_reg   <= en_next;
         edge_reg <= edge_next;
      end
   end

   // ****************************************
   // Priority and vector selection
   // ****************************************
   vic_src_t        live;
   vic_src_t        pick;
   logic [PC_W-1:0] pick_vec;

   // Held requests stay in req_reg until unmasked
   assign live = req_reg & en_reg;

   always_comb begin
      pick = live & (~live + 5'h1);
      case (pick)
         5'h01:   pick_vec = PC_W'(`VIC_VEC_EXT);
         5'h02:   pick_vec = PC_W'(`VIC_VEC_TM0);
         5'h04:   pick_vec = PC_W'(`VIC_VEC_TM1);
         5'h08:   pick_vec = PC_W'(`VIC_VEC_BTM);
         5'h10:   pick_vec = PC_W'(`VIC_VEC_SIO);
         default: pick_vec = '0;
      endcase
   end

   // ****************************************
   // Acceptance sequencer
   // ****************************************
   vic_state_t      state_reg;
   vic_state_t      state_next;
   vic_src_t        src_reg;
   vic_src_t        src_next;
   logic [PC_W-1:0] vec_reg;
   logic [PC_W-1:0] vec_next;
   logic            irq_reg;
   logic            irq_next;
   logic            fetch_reg;
   logic            fetch_next;
   logic            wake_reg;
   logic            wake_next;
   logic            can_take;

   // Depth check holds off a fourth level until a return
   assign can_take = accept_reg & (|live) & (depth_reg != `VIC_NEST_DEPTH);
   assign take     = (state_reg == VIC_OFFER) & ENTRY_ACK_I;
   assign take_src = src_reg;

   always_comb begin
      state_next  = state_reg;
      src_next    = src_reg;
      vec_next    = vec_reg;
      irq_next    = 1'b0;
      fetch_next  = 1'b0;
      accept_next = accept_reg;
      if (ACCEPT_ON_OP_I) begin
         accept_next = 1'b1;
      end
      if (MASK_ALL_OP_I) begin
         accept_next = 1'b0;
      end
      case (state_reg)
         VIC_IDLE: begin
            if (can_take & ~MASK_ALL_OP_I) begin
               state_next = VIC_OFFER;
               src_next   = pick;
               vec_next   = pick_vec;
               irq_next   = 1'b1;
            end
         end
         VIC_OFFER: begin
            irq_next = 1'b1;
            if (take) begin
               state_next  = VIC_IDLE;
               irq_next    = 1'b0;
               fetch_next  = 1'b1;
               accept_next = 1'b0;
            end else if (~accept_next | ~(|(src_reg & live))) begin
               // Offer withdrawn when masked or flag cleared by software
               state_next = VIC_IDLE;
               irq_next   = 1'b0;
            end
         end
         default: begin
            state_next = VIC_IDLE;
         end
      endcase
      wake_next = |live;
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         state_reg  <= VIC_IDLE;
         src_reg    <= 5'h0;
         vec_reg    <= '0;
         irq_reg    <= 1'b0;
         fetch_reg  <= 1'b0;
         accept_reg <= 1'b0;
         wake_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         src_reg    <= src_next;
         vec_reg    <= vec_next;
         irq_reg    <= irq_next;
         fetch_reg  <= fetch_next;
         accept_reg <= accept_next;
         wake_reg   <= wake_next;
      end
   end

   // ****************************************
   // Save stack
   // ****************************************
   // Data buffer and window register stay with handler software
   logic [FRAME_W-1:0] stack_reg  [`VIC_NEST_DEPTH];
   logic [FRAME_W-1:0] stack_next [`VIC_NEST_DEPTH];
   logic [FRAME_W-1:0] rest_reg;
   logic [FRAME_W-1:0] rest_next;
   logic               rest_vld_reg;
   logic               rest_vld_next;
   logic               pop;

   assign pop = RETURN_I & (depth_reg != 2'h0) & ~take;

   always_comb begin
      stack_next    = stack_reg;
      depth_next    = depth_reg;
      rest_next     = rest_reg;
      rest_vld_next = 1'b0;
      if (take) begin
         stack_next[depth_reg] = {RET_ADDR_I, BANK_I, CORE_FLAGS_I};
         depth_next = depth_reg + 2'h1;
      end else if (pop) begin
         rest_next     = stack_reg[depth_reg - 2'h1];
         rest_vld_next = 1'b1;
         depth_next    = depth_reg - 2'h1;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         for (int i = 0; i < `VIC_NEST_DEPTH; i++) begin
            stack_reg[i] <= '0;
         end
         depth_reg    <= 2'h0;
         rest_reg     <= '0;
         rest_vld_reg <= 1'b0;
      end else begin
         stack_reg    <= stack_next;
         depth_reg    <= depth_next;
         rest_reg     <= rest_next;
         rest_vld_reg <= rest_vld_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign HRDATA_O        = rdata_reg;
   assign HREADYOUT_O     = ready_reg;
   assign HRESP_O         = 1'b0;
   assign IRQ_REQ_O       = irq_reg;
   assign VECTOR_O        = vec_reg;
   assign VECTOR_FETCH_O  = fetch_reg;
   assign STANDBY_WAKE_O  = wake_reg;
   assign RESTORE_ADDR_O  = rest_reg[FRAME_W-1:9];
   assign RESTORE_BANK_O  = rest_reg[8:5];
   assign RESTORE_FLAGS_O = rest_reg[4:0];
   assign RESTORE_VALID_O = rest_vld_reg;

endmodule

/* verification/vic_core_model.sv */
// Core sequencer stand-in: acknowledges offers, keeps a shadow stack
// Assumes the controller's core-side ports and one clock
`timescale 1ns/1ns
module vic_core_model #(
   parameter int PC_W = 16
) (
   // Clock, reset, controls
   input  wire logic            clk_i,
   input  wire logic            srst_i,
   input  wire logic            irq_i,
   input  wire logic            ret_i,
   input  wire logic [7:0]      dly_i,
   // State handed to the controller
   output logic                 ack_o,
   output logic      [PC_W-1:0] addr_o,
   output logic      [3:0]      bank_o,
   output logic      [4:0]      flg_o,
   // Frame expected on restore
   output logic      [PC_W-1:0] e_addr_o,
   output logic      [3:0]      e_bank_o,
   output logic      [4:0]      e_flg_o
);
   logic [3:0] n;
   logic [3:0] e_n;
   logic [7:0] w;
   logic [3:0] stk [4];
   int         sp;
   // Frame follows the entry count so each level differs
   // Frame carries no data buffer or window value
   assign addr_o   = {{(PC_W-4){1'b1}}, n};
   assign bank_o   = n;
   assign flg_o    = {1'b1, n};
   assign e_addr_o = {{(PC_W-4){1'b1}}, e_n};
   assign e_bank_o = e_n;
   assign e_flg_o  = {1'b1, e_n};
   always @(posedge clk_i) begin
      if (srst_i) begin
         ack_o <= 1'b0;
         n <= 4'h0;
         e_n <= 4'h0;
         w <= 8'h00;
         sp <= 0;
      end else begin
         w <= irq_i ? w + 8'h01 : 8'h00;
         ack_o <= irq_i && !ack_o && (w >= dly_i);
         if (ack_o && irq_i) begin
            stk[sp] <= n;
            sp <= sp + 1;
            n <= n + 4'h1;
         end else if (ret_i && sp > 0) begin
            e_n <= stk[sp-1];
            sp <= sp - 1;
         end
      end
   end
endmodule

/* verification/vic_top_props.sv */
// Checker for the core-side handshake and nesting of vic_top
// Assumes it is bound into vic_top and sees only its ports
`timescale 1ns/1ns
`include "vic_map.svh"
module vic_top_props #(
   parameter int PC_W = 16
) (
   input wire logic            REF_CLK_I,
   input wire logic            SRST_I,
   input wire logic            ACCEPT_ON_OP_I,
   input wire logic            MASK_ALL_OP_I,
   input wire logic            ENTRY_ACK_I,
   input wire logic            RETURN_I,
   input wire logic            IRQ_REQ_O,
   input wire logic [PC_W-1:0] VECTOR_O,
   input wire logic            VECTOR_FETCH_O,
   input wire logic            RESTORE_VALID_O
);
   // ****
   // Shadow depth and re-arm
   // ****
   // Depth trails the design by a cycle and the arm flag clears a cycle late after a take, so they only bound it
   logic [2:0] dep_reg;
   logic [2:0] dep_next;
   logic       arm_reg;
   logic       arm_next;
   always_comb begin
      dep_next = dep_reg + {2'h0, VECTOR_FETCH_O} - {2'h0, RESTORE_VALID_O};
      arm_next = arm_reg;
      if (VECTOR_FETCH_O) arm_next = 1'b0;
      if (ACCEPT_ON_OP_I) arm_next = 1'b1;
      if (MASK_ALL_OP_I) arm_next = 1'b0;
   end
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         dep_reg <= 3'h0;
         arm_reg <= 1'b0;
      end else begin
         dep_reg <= dep_next;
         arm_reg <= arm_next;
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);
   sequence s_take;
      IRQ_REQ_O && ENTRY_ACK_I;
   endsequence
   sequence s_fetch;
      !IRQ_REQ_O && VECTOR_FETCH_O ##1 !VECTOR_FETCH_O;
   endsequence
   property p_vec;
      IRQ_REQ_O |-> VECTOR_O inside {`VIC_VEC_EXT, `VIC_VEC_TM0, `VIC_VEC_TM1,
                                     `VIC_VEC_BTM, `VIC_VEC_SIO};
   endproperty
   property p_pop;
      RETURN_I && !ENTRY_ACK_I && dep_reg != 3'h0 && !RESTORE_VALID_O |=> RESTORE_VALID_O;
   endproperty
   take_fetch_a: assert property (s_take |=> s_fetch)
      else $error("no fetch after acknowledge");
   vector_set_a: assert property (p_vec)
      else $error("unknown vector offered");
   vector_hold_a: assert property (IRQ_REQ_O && $past(IRQ_REQ_O) |-> $stable(VECTOR_O))
      else $error("vector moved during offer");
   mask_drop_a: assert property (MASK_ALL_OP_I |-> ##2 !IRQ_REQ_O)
      else $error("offer survived mask");
   accept_arm_a: assert property ($rose(IRQ_REQ_O) |-> arm_reg)
      else $error("offer without accept op");
   nest_limit_a: assert property ($rose(IRQ_REQ_O) |-> dep_reg < 3'h3)
      else $error("offer at full depth");
   pop_done_a: assert property (p_pop)
      else $error("return gave no restore");
   pop_cause_a: assert property (RESTORE_VALID_O |-> $past(RETURN_I))
      else $error("restore without return");
endmodule

bind vic_top vic_top_props #(.PC_W(PC_W)) u_vic_top_props (
   .REF_CLK_I, .SRST_I, .ACCEPT_ON_OP_I, .MASK_ALL_OP_I, .ENTRY_ACK_I,
   .RETURN_I, .IRQ_REQ_O, .VECTOR_O, .VECTOR_FETCH_O, .RESTORE_VALID_O
);

/* verification/vic_top_test.sv */
// Self-checking bench for vic_top: registers, edges, priority, nesting
// Assumes vic_core_model as the core and vic_top_props bound in
`timescale 1ns/1ns
module vic_top_test;
   // ****
   // Stimulus and wiring
   // ****
   logic        clk, srst, hsel, hwrite, pin, rdy, irq, fetch, wake, r_val, ack, resp;
   logic [1:0]  htrans;
   logic [7:0]  haddr, dly;
   logic [31:0] hwdata, rdata;
   logic [6:0]  ev;
   logic [15:0] vec, ra, r_addr, ea;
   logic [3:0]  bk, r_bank, eb;
   logic [4:0]  fl, r_flg, ef;
   logic [5:0]  idx [11] = '{6'h0f, 6'h1f, 6'h2e, 6'h2f, 6'h3b, 6'h3c, 6'h3d, 6'h3e,
                             6'h3f, 6'h10, 6'h00};
   int          num_errors = 0;
   int          total_checks = 0;
   int          cyc = 0;
   vic_top u_vic_top (
      .REF_CLK_I(clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(rdy),
      .HRDATA_O(rdata), .HREADYOUT_O(rdy), .HRESP_O(resp), .EXT_PIN_I(pin),
      .TM0_MATCH_I(ev[0]), .TM1_MATCH_I(ev[1]), .BTM_OVF_I(ev[2]), .SIO_END_I(ev[3]),
      .ACCEPT_ON_OP_I(ev[4]), .MASK_ALL_OP_I(ev[5]), .ENTRY_ACK_I(ack), .RETURN_I(ev[6]),
      .RET_ADDR_I(ra), .BANK_I(bk), .CORE_FLAGS_I(fl), .IRQ_REQ_O(irq), .VECTOR_O(vec),
      .VECTOR_FETCH_O(fetch), .STANDBY_WAKE_O(wake), .RESTORE_ADDR_O(r_addr),
      .RESTORE_BANK_O(r_bank), .RESTORE_FLAGS_O(r_flg), .RESTORE_VALID_O(r_val)
   );
   vic_core_model u_vic_core_model (
      .clk_i(clk), .srst_i(srst), .irq_i(irq), .ret_i(ev[6]), .dly_i(dly),
      .ack_o(ack), .addr_o(ra), .bank_o(bk), .flg_o(fl),
      .e_addr_o(ea), .e_bank_o(eb), .e_flg_o(ef)
   );
   always #25 clk = ~clk;
   // ****
   // Tasks
   // ****
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task summarize;
      if (num_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Byte address is four times the register index
   task bus(input logic w, input logic [5:0] i, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {i, 2'h0};
      do @(posedge clk); while (rdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      do @(posedge clk); while (rdy !== 1'b1);
      if (!w) chk(rdata, d);
      chk({31'h0, resp}, 32'h0);
   endtask
   task pulse(input logic [6:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 7'h00;
   endtask
   // Accept op, offer, fetch, then the taken flag must read clear
   task take(input logic [15:0] v);
      pulse(7'h10);
      do @(posedge clk); while (irq !== 1'b1);
      chk({16'h0, vec}, {16'h0, v});
      do @(posedge clk); while (fetch !== 1'b1);
      bus(1'b0, 6'h3a + v[5:0], 32'h0);
   endtask
   task ret;
      pulse(7'h40);
      do @(posedge clk); while (r_val !== 1'b1);
      chk({r_addr, 7'h0, r_bank, r_flg}, {ea, 7'h0, eb, ef});
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         summarize();
      end
   end
   // ****
   // Scenarios
   // ****
   initial begin
      clk = 1'b0; srst = 1'b1; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0;
      haddr = 8'h00; hwdata = 32'h0; pin = 1'b0; ev = 7'h00; dly = 8'd0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      do @(posedge clk); while (rdy !== 1'b1);
      foreach (idx[i]) bus(1'b0, idx[i], 32'h0);
      bus(1'b1, 6'h2f, 32'hffff_ffff);
      bus(1'b0, 6'h2f, 32'hf);
      bus(1'b1, 6'h2e, 32'hffff_ffff);
      bus(1'b0, 6'h2e, 32'h1);
      bus(1'b1, 6'h1f, 32'hffff_ffff);
      bus(1'b0, 6'h1f, 32'h3);
      bus(1'b1, 6'h0f, 32'h1);
      bus(1'b0, 6'h0f, 32'h0);
      bus(1'b1, 6'h2f, 32'h0);
      bus(1'b1, 6'h2e, 32'h0);
      // Polling with everything masked
      pulse(7'h0f);
      for (int i = 0; i < 4; i++) bus(1'b0, 6'h3b + 6'(i), 32'h1);
      chk({31'h0, wake}, 32'h0);
      bus(1'b1, 6'h2e, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, wake}, 32'h1);
      bus(1'b1, 6'h3b, 32'h0);
      bus(1'b0, 6'h3b, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, wake}, 32'h0);
      bus(1'b1, 6'h2e, 32'h0);
      // Every edge-select code against both pin edges
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 6'h1f, 32'(c));
         pin <= 1'b1;
         repeat (8) @(posedge clk);
         bus(1'b0, 6'h0f, 32'h1);
         bus(1'b0, 6'h3f, 32'(c != 1));
         bus(1'b1, 6'h3f, 32'h0);
         bus(1'b0, 6'h3f, 32'h0);
         pin <= 1'b0;
         repeat (8) @(posedge clk);
         bus(1'b0, 6'h3f, 32'(c != 0));
         bus(1'b1, 6'h3f, 32'h0);
      end
      bus(1'b1, 6'h1f, 32'h0);
      pin <= 1'b1;
      repeat (8) @(posedge clk);
      // All five held, enabled in two writes, taken in priority order
      pulse(7'h0f);
      dly <= 8'd3;
      bus(1'b1, 6'h2e, 32'h1);
      bus(1'b1, 6'h2f, 32'hf);
      chk({31'h0, irq}, 32'h0);
      take(16'h5);
      take(16'h4);
      take(16'h3);
      bus(1'b0, 6'h10, 32'h6);
      pulse(7'h10);
      repeat (6) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, 6'h10, 32'h7);
      pulse(7'h20);
      bus(1'b0, 6'h10, 32'h6);
      repeat (3) ret;
      take(16'h2);
      ret;
      take(16'h1);
      ret;
      // Offer withdrawn by mask while the core is slow
      dly <= 8'd40;
      pulse(7'h01);
      pulse(7'h10);
      do @(posedge clk); while (irq !== 1'b1);
      pulse(7'h20);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, 6'h3e, 32'h1);
      dly <= 8'd0;
      take(16'h4);
      ret;
      summarize();
   end
endmodule
